// ==== design/fcs_host_ctrl.sv ====
`timescale 1ns/1ps
`include "fcs_map.svh"

// Behaviour
// - Reset command leaves autoselect mode
// - Exceeded-timing flag set: host writes reset
// - Two unlocks plus autoselect command enter autoselect
// - Program is two unlocks, setup, address/data
// - Writes ignored while busy; hardware reset aborts
// - Query entry writes 98h at 55h/AAh
module fcs_host_ctrl
	import fcs_pkg::*;
#(
	parameter logic [20:0] UNLK1_ADDR = `FCS_UNLK1_ADDR,
	parameter logic [7:0]  UNLK1_DATA = `FCS_UNLK1_DATA,
	parameter logic [20:0] UNLK2_ADDR = `FCS_UNLK2_ADDR,
	parameter logic [7:0]  UNLK2_DATA = `FCS_UNLK2_DATA,
	parameter logic [20:0] CMD_ADDR   = `FCS_CMD_ADDR,
	parameter logic [7:0]  PROG_CMD   = `FCS_PROG_CMD,
	parameter logic [7:0]  ASEL_CMD   = `FCS_ASEL_CMD,
	parameter logic [7:0]  RST_CMD    = `FCS_RST_CMD
)(
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  sys_rst_in,
	// User request port
	input  wire logic                  req_valid_in,
	input  wire fcs_req_s              req_in,
	input  wire logic                  byte_mode_in,
	output logic                       busy_out,
	output logic                       done_out,
	output logic                       fail_out,
	output logic      [`FCS_DW-1:0]    rdata_out,
	output fcs_mode_e                  mode_out,
	// Flash pins
	output fcs_pins_s                  flash_out,
	input  wire logic [`FCS_DW-1:0]    flash_dq_in,
	input  wire logic                  ready_busy_n_in
);

	// Every check runs on the system clock and sleeps in reset
	default clocking chk_cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	// ============================================================
	// Pin synchroniser
	logic [`FCS_SW-1:0] sync_w;        // Clean {ready_busy_n, dq}

	fcs_pin_sync u_sync (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.pin_in     ({ready_busy_n_in, flash_dq_in}),
		.sync_out   (sync_w)
	);

	// ============================================================
	// State
	fcs_state_e          st_q,    st_d;       // Bus engine state
	fcs_op_e             op_q,    op_d;       // Operation in flight
	fcs_mode_e           mode_q,  mode_d;     // Device mode
	fcs_pins_s           pin_q,   pin_d;      // Pin drive
	logic [20:0]         addr_q,  addr_d;     // Target address
	logic [15:0]         data_q,  data_d;     // Target data
	logic [2:0]          step_q,  step_d;     // Write cycle index
	logic [7:0]          cnt_q,   cnt_d;      // Phase counter
	logic                rchk_q,  rchk_d;     // Exceeded flag recheck
	logic                done_q,  done_d;     // Completion pulse
	logic                fail_q,  fail_d;     // Sticky program failure
	logic [15:0]         rdat_q,  rdat_d;     // Last read data
	logic [2:0]          nstep;               // Cycles in the sequence
	logic [20:0]         waddr;               // Address of this cycle
	logic [15:0]         wdata;               // Bus word of this cycle
	logic                last_w;              // Final write cycle
	logic                busy_q,  busy_d;     // Registered busy flag

	// ============================================================
	// Sequence length of the operation in flight
	always_comb begin
		case (op_q)
			FCS_OP_PROG: begin
				nstep = `FCS_PROG_STEPS;
			end
			FCS_OP_ASEL: begin
				nstep = `FCS_ASEL_STEPS;
			end
			default: begin
				nstep = `FCS_ONE_STEP;
			end
		endcase
		last_w = (step_q == nstep - 3'h1);
	end

	// ============================================================
	// Command sequence tables, indexed by the next cycle so the
	// address changes on the same edge as the write strobe falls
	always_comb begin
		waddr = addr_d;
		wdata = {8'h00, RST_CMD};
		case (op_d)
			// Unlock, unlock, setup, address/data
			FCS_OP_PROG: begin
				waddr = (step_d == 3'h0) ? UNLK1_ADDR :
				        (step_d == 3'h1) ? UNLK2_ADDR :
				        (step_d == 3'h2) ? CMD_ADDR : addr_d;
				wdata = (step_d == 3'h0) ? {8'h00, UNLK1_DATA} :
				        (step_d == 3'h1) ? {8'h00, UNLK2_DATA} :
				        (step_d == 3'h2) ? {8'h00, PROG_CMD} : data_d;
			end
			// Unlock, unlock, autoselect command
			FCS_OP_ASEL: begin
				waddr = (step_d == 3'h0) ? UNLK1_ADDR :
				        (step_d == 3'h1) ? UNLK2_ADDR : CMD_ADDR;
				wdata = (step_d == 3'h0) ? {8'h00, UNLK1_DATA} :
				        (step_d == 3'h1) ? {8'h00, UNLK2_DATA} :
				        {8'h00, ASEL_CMD};
			end
			// Query entry, address by bus width
			FCS_OP_QRY: begin
				waddr = byte_mode_in ? `FCS_QRY_BADDR
				                     : `FCS_QRY_WADDR;
				wdata = {8'h00, `FCS_QRY_CMD};
			end
			// Reset command, address ignored by the device
			default: begin
				waddr = addr_d;
				wdata = {8'h00, RST_CMD};
			end
		endcase
	end

	// ============================================================
	// Bus engine next state
	always_comb begin
		st_d   = st_q;
		op_d   = op_q;
		mode_d = mode_q;
		addr_d = addr_q;
		data_d = data_q;
		step_d = step_q;
		cnt_d  = cnt_q + 8'h01;
		rchk_d = rchk_q;
		done_d = 1'b0;
		fail_d = fail_q;
		rdat_d = rdat_q;
		case (st_q)
			// Wait for a request
			FCS_ST_IDLE: begin
				cnt_d = 8'h00;
				if (req_valid_in) begin
					op_d   = req_in.op;
					addr_d = req_in.addr;
					data_d = req_in.data;
					step_d = 3'h0;
					rchk_d = 1'b0;
					fail_d = 1'b0;
					if (req_in.op == FCS_OP_HWRST) begin
						st_d = FCS_ST_HRST;
					end else if (req_in.op == FCS_OP_READ) begin
						st_d = FCS_ST_RLOW;
					end else begin
						st_d = FCS_ST_WLOW;
					end
				end
			end
			// Strobe low for the write pulse width
			FCS_ST_WLOW: begin
				if (cnt_q == 8'(`FCS_WP_CYC - 1)) begin
					st_d  = FCS_ST_WHIGH;
					cnt_d = 8'h00;
				end
			end
			// Strobe high, data held one cycle more
			FCS_ST_WHIGH: begin
				cnt_d  = 8'h00;
				step_d = step_q + 3'h1;
				if (!last_w) begin
					st_d = FCS_ST_WLOW;
				end else if (op_q == FCS_OP_PROG) begin
					// Poll the target until the algorithm ends
					st_d = FCS_ST_RLOW;
				end else begin
					st_d = FCS_ST_IDLE;
					done_d = 1'b1;
					case (op_q)
						FCS_OP_ASEL: begin
							mode_d = FCS_MD_ASEL;
						end
						FCS_OP_QRY: begin
							mode_d = (mode_q == FCS_MD_ASEL) ?
							         FCS_MD_QRY_AS : FCS_MD_QRY;
						end
						default: begin
							mode_d = (mode_q == FCS_MD_QRY_AS) ?
							         FCS_MD_ASEL : FCS_MD_ARRAY;
						end
					endcase
				end
			end
			// Output enable low for access plus sync delay
			FCS_ST_RLOW: begin
				if (cnt_q == 8'(`FCS_ACC_CYC + `FCS_SYNC_CYC - 1)) begin
					st_d   = FCS_ST_EVAL;
					cnt_d  = 8'h00;
					rdat_d = sync_w[`FCS_DW-1:0];
				end
			end
			// Judge the read
			FCS_ST_EVAL: begin
				cnt_d = 8'h00;
				if (op_q != FCS_OP_PROG) begin
					st_d   = FCS_ST_IDLE;
					done_d = 1'b1;
				end else if ((rdat_q[`FCS_POLL_BIT] ==
				              data_q[`FCS_POLL_BIT]) &&
				             sync_w[`FCS_RB_BIT]) begin
					// Polling bit matches and device ready
					st_d   = FCS_ST_IDLE;
					done_d = 1'b1;
				end else if (rdat_q[`FCS_EXTO_BIT] && rchk_q) begin
					// Timed out: reset back to read-array
					fail_d = 1'b1;
					op_d   = FCS_OP_RESET;
					step_d = 3'h0;
					st_d   = FCS_ST_WLOW;
				end else begin
					rchk_d = rdat_q[`FCS_EXTO_BIT];
					st_d   = FCS_ST_RLOW;
				end
			end
			// Hardware reset pulse aborts everything
			FCS_ST_HRST: begin
				mode_d = FCS_MD_ARRAY;
				if (cnt_q == 8'(`FCS_RP_CYC - 1)) begin
					st_d   = FCS_ST_IDLE;
					cnt_d  = 8'h00;
					done_d = 1'b1;
				end
			end
			default: begin
				st_d = FCS_ST_IDLE;
			end
		endcase
		// Busy whenever the engine is away from idle
		busy_d = (st_d != FCS_ST_IDLE);
	end

	// ============================================================
	// Pin drive from the next state
	always_comb begin
		pin_d        = '0;
		pin_d.ce_n   = 1'b1;
		pin_d.we_n   = 1'b1;
		pin_d.oe_n   = 1'b1;
		pin_d.rst_n  = (st_d != FCS_ST_HRST);
		pin_d.byte_n = !byte_mode_in;
		pin_d.addr   = pin_q.addr;
		case (st_d)
			// Both strobes low; after a previous write cycle only the write strobe falls
			FCS_ST_WLOW: begin
				pin_d.ce_n   = 1'b0;
				pin_d.we_n   = 1'b0;
				pin_d.dq_oe  = 1'b1;
				pin_d.addr   = waddr;
				pin_d.dq_out = wdata;
			end
			// Write strobe rises first; chip select stays low unless idle follows
			FCS_ST_WHIGH: begin
				pin_d.ce_n   = 1'b0;
				pin_d.dq_oe  = 1'b1;
				pin_d.dq_out = pin_q.dq_out;
			end
			// Read cycle
			FCS_ST_RLOW: begin
				pin_d.ce_n   = 1'b0;
				pin_d.oe_n   = 1'b0;
				pin_d.addr   = addr_d;
			end
			default: begin
				pin_d.ce_n   = 1'b1;
			end
		endcase
	end

	// ============================================================
	// Registers
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st_q   <= FCS_ST_HRST;
			op_q   <= FCS_OP_HWRST;
			mode_q <= FCS_MD_ARRAY;
			busy_q <= 1'b1;
			// Strobes idle high, device held in reset
			pin_q  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
			           byte_n: 1'b1, default: '0};
			addr_q <= '0;
			data_q <= '0;
			step_q <= 3'h0;
			cnt_q  <= 8'h00;
			rchk_q <= 1'b0;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			rdat_q <= '0;
		end else begin
			st_q   <= st_d;
			op_q   <= op_d;
			mode_q <= mode_d;
			pin_q  <= pin_d;
			addr_q <= addr_d;
			data_q <= data_d;
			step_q <= step_d;
			cnt_q  <= cnt_d;
			rchk_q <= rchk_d;
			done_q <= done_d;
			fail_q <= fail_d;
			rdat_q <= rdat_d;
			busy_q <= busy_d;
		end
	end

	// Outputs straight from flops
	assign busy_out  = busy_q;
	assign done_out  = done_q;
	assign fail_out  = fail_q;
	assign rdata_out = rdat_q;
	assign mode_out  = mode_q;
	assign flash_out = pin_q;

	// ============================================================
	// Checks
	chk_we_pulse_len: assert property (
		$fell(pin_q.we_n) |-> (!pin_q.we_n)[*5] ##1 pin_q.we_n)
		else $error("write pulse width wrong");

	chk_data_first_rise: assert property (
		$rose(pin_q.we_n) |-> !pin_q.ce_n && pin_q.dq_oe
		&& $stable(pin_q.dq_out) && $stable(pin_q.addr))
		else $error("data not held through write strobe rise");

	chk_prog_setup_seq: assert property (
		(st_q == FCS_ST_WHIGH && op_q == FCS_OP_PROG && step_q == 3'h2)
		|-> pin_q.dq_out[7:0] == PROG_CMD ##1 !pin_q.we_n
		&& pin_q.addr == addr_q && pin_q.dq_out == data_q)
		else $error("program sequence out of order");

	chk_asel_mode: assert property (
		(done_q && op_q == FCS_OP_ASEL) |-> mode_q == FCS_MD_ASEL)
		else $error("autoselect entry not tracked");

	chk_qry_addr: assert property (
		($fell(pin_q.we_n) && op_q == FCS_OP_QRY) |->
		pin_q.dq_out[7:0] == `FCS_QRY_CMD &&
		pin_q.addr == (pin_q.byte_n ? `FCS_QRY_WADDR : `FCS_QRY_BADDR))
		else $error("query entry address or code wrong");

	chk_qry_back_asel: assert property (
		(done_d && op_q == FCS_OP_RESET && mode_q == FCS_MD_QRY_AS
		&& st_q == FCS_ST_WHIGH) |=> mode_q == FCS_MD_ASEL)
		else $error("reset from query did not return to autoselect");

	chk_exto_reset: assert property (
		$rose(fail_q) |-> !pin_q.we_n && pin_q.dq_out[7:0] == RST_CMD)
		else $error("timeout not followed by reset command");

	chk_hwrst_len: assert property (
		$fell(pin_q.rst_n) |-> ##62 !pin_q.rst_n ##1 pin_q.rst_n)
		else $error("hardware reset pulse length wrong");

	chk_asel_exit: assert property (
		($past(mode_q) == FCS_MD_ASEL && mode_q == FCS_MD_ARRAY) |->
		$past(op_q) == FCS_OP_RESET || $past(op_q) == FCS_OP_HWRST)
		else $error("autoselect left without reset");

endmodule

// ==== design/fcs_map.svh ====
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH

// ============================================================
// Clock and pin timing
`define FCS_CLK_NS      8
`define FCS_T_WP_NS     35
`define FCS_T_ACC_NS    70
`define FCS_T_RP_NS     500
// Least times round up to whole clock cycles
`define FCS_WP_CYC      ((`FCS_T_WP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_ACC_CYC     ((`FCS_T_ACC_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_RP_CYC      ((`FCS_T_RP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
// Synchroniser depth added to every read
`define FCS_SYNC_CYC    3

// ============================================================
// Bus widths
`define FCS_AW          21
`define FCS_DW          16
`define FCS_SW          17

// ============================================================
// Query entry command
`define FCS_QRY_CMD     8'h98
`define FCS_QRY_WADDR   21'h000055
`define FCS_QRY_BADDR   21'h0000AA

// ============================================================
// Command codes (arbitrary defaults, not known for the part)
`define FCS_UNLK1_ADDR  21'h000123
`define FCS_UNLK1_DATA  8'hC3
`define FCS_UNLK2_ADDR  21'h000321
`define FCS_UNLK2_DATA  8'h3C
`define FCS_CMD_ADDR    21'h000123
`define FCS_PROG_CMD    8'hA5
`define FCS_ASEL_CMD    8'h5A
`define FCS_RST_CMD     8'hFF

// ============================================================
// Status bit positions
`define FCS_POLL_BIT    7
`define FCS_EXTO_BIT    5
`define FCS_RB_BIT      16

// ============================================================
// Sequence lengths
`define FCS_PROG_STEPS  3'h4
`define FCS_ASEL_STEPS  3'h3
`define FCS_ONE_STEP    3'h1

`endif

// ==== design/fcs_pkg.sv ====
package fcs_pkg;

	// ============================================================
	// User operations
	typedef enum logic [2:0] {
		FCS_OP_READ    = 3'h0,
		FCS_OP_PROG    = 3'h1,
		FCS_OP_ASEL    = 3'h2,
		FCS_OP_QRY     = 3'h3,
		FCS_OP_RESET   = 3'h4,
		FCS_OP_HWRST   = 3'h5
	} fcs_op_e;

	// ============================================================
	// Device mode as tracked by the controller
	typedef enum logic [1:0] {
		FCS_MD_ARRAY   = 2'h0,
		FCS_MD_ASEL    = 2'h1,
		FCS_MD_QRY     = 2'h2,
		FCS_MD_QRY_AS  = 2'h3
	} fcs_mode_e;

	// ============================================================
	// Bus engine states, one-hot
	typedef enum logic [5:0] {
		FCS_ST_IDLE    = 6'h01,
		FCS_ST_WLOW    = 6'h02,
		FCS_ST_WHIGH   = 6'h04,
		FCS_ST_RLOW    = 6'h08,
		FCS_ST_EVAL    = 6'h10,
		FCS_ST_HRST    = 6'h20
	} fcs_state_e;

	// ============================================================
	// User request
	typedef struct packed {
		fcs_op_e       op;
		logic [20:0]   addr;
		logic [15:0]   data;
	} fcs_req_s;

	// ============================================================
	// Flash pin drive
	typedef struct packed {
		logic          ce_n;
		logic          we_n;
		logic          oe_n;
		logic          rst_n;
		logic          byte_n;
		logic          dq_oe;
		logic [20:0]   addr;
		logic [15:0]   dq_out;
	} fcs_pins_s;

endpackage

// ==== design/fcs_pin_sync.sv ====
`timescale 1ns/1ps
`include "fcs_map.svh"

// Three-stage pin synchroniser; a bit moves once stages 2 and 3 agree
module fcs_pin_sync
	import fcs_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  sys_rst_in,
	// Pins and clean copy
	input  wire logic [`FCS_SW-1:0]    pin_in,
	output logic      [`FCS_SW-1:0]    sync_out
);

	// ============================================================
	// Per-bit chain
	genvar i;
	generate
		for (i = 0; i < `FCS_SW; i++) begin : g_bit
			logic s1_q;        // Metastable stage, read by s2 only
			logic s2_q;        // Second stage
			logic s3_q;        // Third stage
			logic o_q;         // Accepted level
			logic s1_d;
			logic s2_d;
			logic s3_d;
			logic o_d;

			// Next values
			always_comb begin
				s1_d = pin_in[i];
				s2_d = s1_q;
				s3_d = s2_q;
				// Accept only when stages agree
				o_d = (s2_q == s3_q) ? s3_q : o_q;
			end

			// Registers
			always_ff @(posedge clk_in) begin
				if (sys_rst_in) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					o_q  <= 1'b0;
				end else begin
					s1_q <= s1_d;
					s2_q <= s2_d;
					s3_q <= s3_d;
					o_q  <= o_d;
				end
			end

			assign sync_out[i] = o_q;
		end
	endgenerate

endmodule

// ==== test/fcs_flash_model.sv ====
`timescale 1ns/1ps
`include "fcs_map.svh"

// ============================================================
// Behavioural flash device seen through its pins
module fcs_flash_model
	import fcs_pkg::*;
#(
	parameter logic [15:0] MFR_ID  = 16'h00A1, // Arbitrary value
	parameter logic [15:0] CONT_ID = 16'h00B2, // Arbitrary value
	parameter logic [15:0] DEV_ID  = 16'h00C3, // Arbitrary value
	parameter logic [5:0]  PROT_SA = 6'h03,
	parameter int          PROG_NS = 3000
)(
	// Pins from the controller
	input  wire fcs_pins_s   pins_in,
	input  wire logic        fault_in,
	// Device drive
	output logic [15:0]      dq_out,
	output logic             ready_busy_n_out
);
	logic [15:0] mem [int];  // Programmed words, rest erased
	fcs_mode_e   mode_q;     // Current mode
	int          step_q;     // Cycles seen of a sequence
	int          gen_q;      // Bumped to cancel a running program
	logic [20:0] lat_addr;   // Address of the write in progress
	logic        wr_act;     // Write cycle open
	logic        busy_q;     // Program algorithm running
	logic        tog_q;      // Toggling status bit
	logic [15:0] pdat_q;     // Data being programmed
	logic [15:0] cur;        // Value for the current read
	logic [15:0] last_q;     // Last value shown
	logic [20:0] word;       // Word address of the read
	logic [5:0]  sector_address_field;

	// Extended query table
	function automatic logic [15:0] qry(input logic [7:0] w);
		case (w)
		8'h40: return 16'h0050;
		8'h41: return 16'h0052;
		8'h42: return 16'h0049;
		8'h43: return 16'h0031;
		8'h44: return 16'h0030;
		8'h46: return 16'h0002;
		8'h47, 8'h48: return 16'h0001;
		8'h49: return 16'h0004;
		default: return 16'h0000;
		endcase
	endfunction

	initial begin
		mode_q = FCS_MD_ARRAY;
		step_q = 0;
		gen_q = 0;
		wr_act = 0;
		busy_q = 0;
		tog_q = 0;
		last_q = '0;
	end

	assign word = pins_in.byte_n ? pins_in.addr : pins_in.addr >> 1;
	assign sector_address_field = pins_in.addr[20:15];
	assign ready_busy_n_out = !busy_q;
	// Released bus shows the inverse of the last value
	assign dq_out = (!pins_in.ce_n && !pins_in.oe_n) ? cur : ~last_q;

	// Read data by mode
	always @* begin
		if (busy_q)
			cur = {8'h00, ~pdat_q[7], tog_q, fault_in, 5'h00};
		else if (mode_q == FCS_MD_QRY || mode_q == FCS_MD_QRY_AS)
			cur = qry(word[7:0]);
		else if (mode_q == FCS_MD_ASEL) begin
			case (pins_in.addr[7:0])
			8'h00: cur = MFR_ID;
			8'h11: cur = CONT_ID;
			8'h01: cur = DEV_ID;
			default: cur = {15'h0, sector_address_field == PROT_SA};
			endcase
		end else
			cur = mem.exists(int'(word)) ? mem[int'(word)] : 16'hFFFF;
	end

	always @(posedge pins_in.oe_n)
		last_q = cur;
	always @(negedge pins_in.oe_n)
		if (busy_q)
			tog_q = ~tog_q;

	// Hardware reset aborts everything
	always @(negedge pins_in.rst_n) begin
		gen_q++;
		busy_q = 0;
		step_q = 0;
		wr_act = 0;
		mode_q = FCS_MD_ARRAY;
	end

	// Address at the later fall, data at the first rise
	always @(negedge pins_in.we_n or negedge pins_in.ce_n)
		if (!pins_in.we_n && !pins_in.ce_n && pins_in.oe_n && pins_in.rst_n) begin
			lat_addr = pins_in.addr;
			wr_act = 1;
		end
	always @(posedge pins_in.we_n or posedge pins_in.ce_n)
		if (wr_act) begin
			wr_act = 0;
			cmd(lat_addr, pins_in.dq_out);
		end

	// Command decoder
	task automatic cmd(input logic [20:0] a, input logic [15:0] d);
		int g;
		g = gen_q;
		if (busy_q) begin
			if (fault_in && d[7:0] == `FCS_RST_CMD) begin
				gen_q++;
				busy_q = 0;
				mode_q = FCS_MD_ARRAY;
			end
		end else if (d[7:0] == `FCS_RST_CMD) begin
			step_q = 0;
			mode_q = mode_q == FCS_MD_QRY_AS ? FCS_MD_ASEL : FCS_MD_ARRAY;
		end else if (step_q == 0 && d[7:0] == `FCS_QRY_CMD && a ==
			(pins_in.byte_n ? `FCS_QRY_WADDR : `FCS_QRY_BADDR))
			mode_q = mode_q == FCS_MD_ASEL ? FCS_MD_QRY_AS : FCS_MD_QRY;
		else if (step_q == 0 && a == `FCS_UNLK1_ADDR && d[7:0] == `FCS_UNLK1_DATA)
			step_q = 1;
		else if (step_q == 1 && a == `FCS_UNLK2_ADDR && d[7:0] == `FCS_UNLK2_DATA)
			step_q = 2;
		else if (step_q == 2 && a == `FCS_CMD_ADDR && d[7:0] == `FCS_PROG_CMD)
			step_q = 3;
		else if (step_q == 2 && a == `FCS_CMD_ADDR && d[7:0] == `FCS_ASEL_CMD) begin
			step_q = 0;
			mode_q = FCS_MD_ASEL;
		end else if (step_q == 3) begin
			step_q = 0;
			busy_q = 1;
			pdat_q = d;
			fork
				begin
					#(PROG_NS);
					if (g == gen_q && !fault_in) begin
						mem[int'(a)] = (mem.exists(int'(a)) ? mem[int'(a)]
							: 16'hFFFF) & d;
						busy_q = 0;
					end
				end
			join_none
		end else begin
			step_q = 0;
			mode_q = FCS_MD_ARRAY;
		end
	endtask
endmodule

// ==== test/fcs_host_ctrl_tb.sv ====
`timescale 1ns/1ps
`include "fcs_map.svh"

// ============================================================
// Self-checking bench for the flash host controller
module fcs_host_ctrl_tb;
	import fcs_pkg::*;
	localparam logic [15:0] MFR = 16'h00A1;  // Arbitrary value
	localparam logic [15:0] CNT = 16'h00B2;  // Arbitrary value
	localparam logic [15:0] DEV = 16'h00C3;  // Arbitrary value
	logic        clk_in       = 1'b0;
	logic        sys_rst_in   = 1'b1;
	logic        req_valid_in = 1'b0;
	fcs_req_s    req_in       = '0;
	logic        byte_mode_in = 1'b0;
	logic        fault        = 1'b0;  // Device never finishes
	logic        busy_out, done_out, fail_out, rb_n;
	logic [15:0] rdata_out, dev_dq, dq_wire;
	fcs_mode_e   mode_out;
	fcs_pins_s   flash_out;
	int          errors       = 0;
	int          tests_run    = 0;
	logic [15:0] qtab [13] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031,
		16'h0030, 16'h0000, 16'h0002, 16'h0001, 16'h0001, 16'h0004,
		16'h0000, 16'h0000, 16'h0000};

	always #4 clk_in = ~clk_in;
	assign dq_wire = flash_out.dq_oe ? flash_out.dq_out : dev_dq;

	fcs_host_ctrl u_fcs_host_ctrl (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.req_valid_in(req_valid_in), .req_in(req_in),
		.byte_mode_in(byte_mode_in), .busy_out(busy_out), .done_out(done_out),
		.fail_out(fail_out), .rdata_out(rdata_out), .mode_out(mode_out),
		.flash_out(flash_out), .flash_dq_in(dq_wire), .ready_busy_n_in(rb_n));
	fcs_flash_model #(.MFR_ID(MFR), .CONT_ID(CNT), .DEV_ID(DEV))
		u_fcs_flash_model (.pins_in(flash_out), .fault_in(fault),
		.dq_out(dev_dq), .ready_busy_n_out(rb_n));

	// Verdict and end of run
	task automatic conclude();
		$display("Counts: %0d checks, %0d mismatches", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk_data(string nm, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_mode(fcs_mode_e e);
		chk_data("mode", {14'h0, e}, {14'h0, mode_out});
	endtask
	task automatic chk_bit(string nm, logic e, logic g);
		chk_data(nm, {15'h0, e}, {15'h0, g});
	endtask

	// One user operation, waits for its done pulse
	task automatic op(fcs_op_e o, logic [20:0] a, logic [15:0] d);
		int n;
		for (n = 0; n < 5000 && busy_out !== 1'b0; n++) begin
			@(posedge clk_in);
			#1;
		end
		if (n == 5000) begin
			errors++;
			$display("ERROR busy expected 0 seen %b", busy_out);
			conclude();
		end
		@(posedge clk_in);
		#1 req_valid_in = 1'b1;
		req_in = '{o, a, d};
		@(posedge clk_in);
		#1 req_valid_in = 1'b0;
		for (n = 0; n < 5000 && done_out !== 1'b1; n++) begin
			@(posedge clk_in);
			#1;
		end
		if (n == 5000) begin
			errors++;
			$display("ERROR done expected 1 seen %b", done_out);
			conclude();
		end
	endtask
	task automatic rd(string nm, logic [20:0] a, logic [15:0] e);
		op(FCS_OP_READ, a, 16'h0000);
		chk_data(nm, e, rdata_out);
	endtask

	initial begin
		repeat (5) @(posedge clk_in);
		#1 sys_rst_in = 1'b0;
		// Program, overwrite and cross sectors
		rd("erased", 21'h000010, 16'hFFFF);
		chk_mode(FCS_MD_ARRAY);
		op(FCS_OP_PROG, 21'h000010, 16'h1234);
		chk_bit("fail", 1'b0, fail_out);
		rd("prog", 21'h000010, 16'h1234);
		op(FCS_OP_PROG, 21'h000010, 16'hFF0F);
		rd("no set", 21'h000010, 16'h1204);
		op(FCS_OP_PROG, 21'h17FFFF, 16'hA5A5);
		op(FCS_OP_PROG, 21'h180000, 16'h5A5A);
		rd("sect a", 21'h17FFFF, 16'hA5A5);
		rd("sect b", 21'h180000, 16'h5A5A);
		$display("test program done");
		// Query table in word mode
		op(FCS_OP_QRY, `FCS_QRY_WADDR, {8'h00, `FCS_QRY_CMD});
		chk_mode(FCS_MD_QRY);
		for (int i = 0; i < 13; i++)
			rd("query", 21'(64 + i), qtab[i]);
		op(FCS_OP_RESET, 21'h000777, 16'h0000);
		chk_mode(FCS_MD_ARRAY);
		rd("after query", 21'h000010, 16'h1204);
		$display("test query done");
		// Autoselect, nested query, exits
		op(FCS_OP_ASEL, `FCS_CMD_ADDR, 16'h0000);
		chk_mode(FCS_MD_ASEL);
		repeat (2) rd("maker", 21'h1F0000, MFR);
		rd("cont", 21'h000011, CNT);
		rd("device", 21'h0A0001, DEV);
		rd("prot", 21'h018002, 16'h0001);
		rd("unprot", 21'h028002, 16'h0000);
		op(FCS_OP_QRY, `FCS_QRY_WADDR, {8'h00, `FCS_QRY_CMD});
		chk_mode(FCS_MD_QRY_AS);
		rd("query as", 21'h000040, 16'h0050);
		op(FCS_OP_RESET, 21'h000000, 16'h0000);
		chk_mode(FCS_MD_ASEL);
		rd("device as", 21'h000001, DEV);
		op(FCS_OP_RESET, 21'h000000, 16'h0000);
		chk_mode(FCS_MD_ARRAY);
		rd("array", 21'h000010, 16'h1204);
		$display("test autoselect done");
		// Program that exceeds its time
		fault = 1'b1;
		op(FCS_OP_PROG, 21'h000020, 16'h0000);
		chk_bit("fail", 1'b1, fail_out);
		chk_mode(FCS_MD_ARRAY);
		fault = 1'b0;
		rd("abandoned", 21'h000020, 16'hFFFF);
		chk_bit("fail clear", 1'b0, fail_out);
		$display("test timeout done");
		// Hardware reset out of query mode
		op(FCS_OP_QRY, `FCS_QRY_WADDR, {8'h00, `FCS_QRY_CMD});
		op(FCS_OP_HWRST, 21'h000000, 16'h0000);
		chk_mode(FCS_MD_ARRAY);
		rd("after hw reset", 21'h000010, 16'h1204);
		$display("test hardware reset done");
		// Byte bus query at doubled address
		byte_mode_in = 1'b1;
		op(FCS_OP_QRY, `FCS_QRY_BADDR, {8'h00, `FCS_QRY_CMD});
		chk_bit("byte pin", 1'b0, flash_out.byte_n);
		op(FCS_OP_READ, 21'h000080, 16'h0000);
		chk_data("query byte", 16'h0050, {8'h00, rdata_out[7:0]});
		op(FCS_OP_RESET, 21'h000000, 16'h0000);
		chk_mode(FCS_MD_ARRAY);
		$display("test byte mode done");
		conclude();
	end
endmodule
